// file: core/adm_pkg.sv
package adm_pkg;
  // control word layout
  localparam int RW_BIT  = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam int DAT_MSB = 7;

  // register indices carried in the control word
  localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FMT_CTRL    = 7'h12;
  localparam logic [6:0] IDX_OUT_CTRL    = 7'h13;

  // reset values and the output control read mask
  localparam logic [7:0] ATTEN_RST    = 8'hFF;
  localparam logic [7:0] FMT_CTRL_RST = 8'h50;
  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_CTRL_RD_MASK = 8'hF3;

  // format/emphasis/mute control fields
  localparam int LOAD_EN_POS = 7;
  localparam int FMT_LSB     = 4;
  localparam int DMF_LSB     = 2;
  localparam int DME_POS     = 1;
  localparam int MUTE_POS    = 0;

  // output/filter/ramp control fields
  localparam int REV_POS  = 7;
  localparam int ATS_LSB  = 5;
  localparam int OPE_POS  = 4;
  localparam int FLT_POS  = 1;
  localparam int ZERO_HOLD_MUTE_ENABLE_POS = 0;

  // attenuator codes
  localparam logic [7:0] INF_MUTE_MAX = 8'h0E;
  localparam logic [7:0] ATTEN_FLOOR  = 8'h00;

  // serial format encodings
  localparam logic [2:0] FMT_RJ16  = 3'h0;
  localparam logic [2:0] FMT_RJ20  = 3'h1;
  localparam logic [2:0] FMT_RJ24  = 3'h2;
  localparam logic [2:0] FMT_LJ24  = 3'h3;
  localparam logic [2:0] FMT_I2S16 = 3'h4;
  localparam logic [2:0] FMT_I2S24 = 3'h5;

  // ramp intervals in word-clock periods, minus one
  localparam logic [2:0] RAMP_DIV1 = 3'h0;
  localparam logic [2:0] RAMP_DIV2 = 3'h1;
  localparam logic [2:0] RAMP_DIV4 = 3'h3;
  localparam logic [2:0] RAMP_DIV8 = 3'h7;
endpackage : adm_pkg

// file: core/adm_mode_regs.sv
`timescale 1ns/1ns
`default_nettype none
module adm_mode_regs
  import adm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        word_clock,
  input  wire logic        stream_mode,
  input  wire logic        ext_filter_through,
  input  wire logic        zero_left,
  input  wire logic        zero_right,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic [7:0]       left_level,
  output logic [7:0]       right_level,
  output logic             left_inf_mute,
  output logic             right_inf_mute,
  output logic [2:0]       serial_format_sel,
  output logic [2:0]       ext_filter_format,
  output logic             ext_format_active,
  output logic [1:0]       deemph_rate_sel,
  output logic [1:0]       fir_perf_sel,
  output logic             deemph_enable,
  output logic             phase_invert,
  output logic             output_disable,
  output logic             rolloff_sel,
  output logic             zero_hold_active
);

  typedef struct packed {
    logic [2:0] wclk_sync;
    logic       wclk_level;
    logic [7:0] left_atten_code;
    logic [7:0] right_atten_code;
    logic [7:0] fmt_ctrl;
    logic [7:0] out_ctrl;
    logic [7:0] left_applied;
    logic [7:0] right_applied;
    logic [7:0] left_level;
    logic [7:0] right_level;
    logic [2:0] ramp_cnt;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       left_inf;
    logic       right_inf;
    logic [2:0] audio_fmt;
    logic [2:0] ext_fmt;
    logic       ext_active;
    logic [1:0] deemph_rate;
    logic [1:0] fir_perf;
    logic       deemph_on;
    logic       phase_inv;
    logic       out_dis;
    logic       rolloff;
    logic       zero_hold;
  } adm_state_t;

  adm_state_t state_reg;
  adm_state_t state_next;

  // all reset values gathered in one constant function
  function automatic adm_state_t adm_reset_state();
    adm_state_t s;
    s = '0;
    s.left_atten_code  = ATTEN_RST;
    s.right_atten_code = ATTEN_RST;
    s.fmt_ctrl         = FMT_CTRL_RST;
    s.out_ctrl         = OUT_CTRL_RST;
    s.left_applied     = ATTEN_RST;
    s.right_applied    = ATTEN_RST;
    s.left_level       = ATTEN_RST;
    s.right_level      = ATTEN_RST;
    s.audio_fmt        = FMT_I2S24;
    return s;
  endfunction : adm_reset_state
  localparam adm_state_t STATE_RST = adm_reset_state();

  // interval between attenuator steps, in word-clock periods minus one
  function automatic logic [2:0] ramp_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    ramp_limit = RAMP_DIV1;
      2'h1:    ramp_limit = RAMP_DIV2;
      2'h2:    ramp_limit = RAMP_DIV4;
      default: ramp_limit = RAMP_DIV8;
    endcase
  endfunction : ramp_limit

  // one half-dB step toward the target, never overshooting
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 8'h01;
    end else if (cur > tgt) begin
      step_toward = cur - 8'h01;
    end else begin
      step_toward = cur;
    end
  endfunction : step_toward

  logic [6:0] cmd_idx;
  logic       cmd_wr;
  logic       cmd_rd;
  logic       wclk_rise;
  logic       ramp_tick;
  logic       load_en;
  logic       soft_mute;
  logic [7:0] left_target;
  logic [7:0] right_target;

  // command decode straight from the word presented with the strobe
  assign cmd_idx = cmd_word[IDX_MSB:IDX_LSB];
  assign cmd_wr  = cmd_valid & ~cmd_word[RW_BIT];
  assign cmd_rd  = cmd_valid & cmd_word[RW_BIT];

  // word clock edge seen only once the last two sync stages agree
  assign wclk_rise = (state_reg.wclk_sync[1] == state_reg.wclk_sync[2])
                   & state_reg.wclk_sync[2] & ~state_reg.wclk_level;
  // at or past the limit, so lowering the rate never waits for the counter to wrap
  assign ramp_tick = wclk_rise & (state_reg.ramp_cnt >= ramp_limit(state_reg.out_ctrl[ATS_LSB +: 2]));

  assign load_en   = state_reg.fmt_ctrl[LOAD_EN_POS];
  assign soft_mute = state_reg.fmt_ctrl[MUTE_POS];
  // soft mute overrides the applied code and ramps to the bottom code
  assign left_target  = soft_mute ? ATTEN_FLOOR : state_reg.left_applied;
  assign right_target = soft_mute ? ATTEN_FLOOR : state_reg.right_applied;

  always_comb begin
    state_next = state_reg;
    // pin synchroniser: stage 0 feeds only stage 1
    state_next.wclk_sync = {state_reg.wclk_sync[1:0], word_clock};
    if (state_reg.wclk_sync[1] == state_reg.wclk_sync[2]) begin
      state_next.wclk_level = state_reg.wclk_sync[2];
    end

    // ramp divider; restarts at every step so a rate change acts at once
    if (ramp_tick) begin
      state_next.ramp_cnt = 3'h0;
    end else if (wclk_rise) begin
      state_next.ramp_cnt = state_reg.ramp_cnt + 3'h1;
    end

    // register writes; unknown indices are dropped silently
    if (cmd_wr) begin
      case (cmd_idx)
        IDX_LEFT_ATTEN:  state_next.left_atten_code  = cmd_word[DAT_MSB:0];
        IDX_RIGHT_ATTEN: state_next.right_atten_code = cmd_word[DAT_MSB:0];
        IDX_FMT_CTRL:    state_next.fmt_ctrl         = cmd_word[DAT_MSB:0];
        IDX_OUT_CTRL:    state_next.out_ctrl         = cmd_word[DAT_MSB:0];
        default:         state_next.out_ctrl         = state_reg.out_ctrl;
      endcase
    end

    // readback one cycle after the strobe; unmapped reads return zero
    state_next.rd_valid = cmd_rd;
    state_next.rd_data  = 8'h00;
    if (cmd_rd) begin
      case (cmd_idx)
        IDX_LEFT_ATTEN:  state_next.rd_data = state_reg.left_atten_code;
        IDX_RIGHT_ATTEN: state_next.rd_data = state_reg.right_atten_code;
        IDX_FMT_CTRL:    state_next.rd_data = state_reg.fmt_ctrl;
        IDX_OUT_CTRL:    state_next.rd_data = state_reg.out_ctrl & OUT_CTRL_RD_MASK;
        default:         state_next.rd_data = 8'h00;
      endcase
    end

    // one shared gate: codes reach the attenuators only while it is set
    if (load_en) begin
      state_next.left_applied  = state_reg.left_atten_code;
      state_next.right_applied = state_reg.right_atten_code;
    end

    // attenuators walk one code per ramp interval instead of jumping
    if (ramp_tick) begin
      state_next.left_level  = step_toward(state_reg.left_level, left_target);
      state_next.right_level = step_toward(state_reg.right_level, right_target);
    end
    // low codes mean infinite attenuation rather than a finite level
    state_next.left_inf  = state_reg.left_level <= INF_MUTE_MAX;
    state_next.right_inf = state_reg.right_level <= INF_MUTE_MAX;

    // format field goes to the audio port or the external filter port
    state_next.ext_active = ext_filter_through;
    state_next.audio_fmt  = ext_filter_through ? state_reg.audio_fmt
                                               : state_reg.fmt_ctrl[FMT_LSB +: 3];
    state_next.ext_fmt    = ext_filter_through ? state_reg.fmt_ctrl[FMT_LSB +: 3] : 3'h0;

    // the rate field serves de-emphasis or the stream FIR, never both
    state_next.deemph_rate = stream_mode ? 2'h0 : state_reg.fmt_ctrl[DMF_LSB +: 2];
    state_next.fir_perf    = stream_mode ? state_reg.fmt_ctrl[DMF_LSB +: 2] : 2'h0;
    state_next.deemph_on   = state_reg.fmt_ctrl[DME_POS] & ~stream_mode;

    state_next.phase_inv = state_reg.out_ctrl[REV_POS];
    state_next.out_dis   = state_reg.out_ctrl[OPE_POS];
    state_next.rolloff   = state_reg.out_ctrl[FLT_POS];
    // zero flags come from logic on this clock, so no synchroniser
    state_next.zero_hold = state_reg.out_ctrl[ZERO_HOLD_MUTE_ENABLE_POS] & zero_left & zero_right
                         & ~stream_mode;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // every output comes straight from the state register
  assign rd_valid          = state_reg.rd_valid;
  assign rd_data           = state_reg.rd_data;
  assign left_level        = state_reg.left_level;
  assign right_level       = state_reg.right_level;
  assign left_inf_mute     = state_reg.left_inf;
  assign right_inf_mute    = state_reg.right_inf;
  assign serial_format_sel = state_reg.audio_fmt;
  assign ext_filter_format = state_reg.ext_fmt;
  assign ext_format_active = state_reg.ext_active;
  assign deemph_rate_sel   = state_reg.deemph_rate;
  assign fir_perf_sel      = state_reg.fir_perf;
  assign deemph_enable     = state_reg.deemph_on;
  assign phase_invert      = state_reg.phase_inv;
  assign output_disable    = state_reg.out_dis;
  assign rolloff_sel       = state_reg.rolloff;
  assign zero_hold_active  = state_reg.zero_hold;

  // a read strobe is answered on the next edge, and only then
  chk_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_rd |=> rd_valid)
    else $error("read strobe not answered next cycle");

  // a write to the left index lands the data byte in the left code
  chk_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_wr && cmd_idx == IDX_LEFT_ATTEN |=> state_reg.left_atten_code == $past(cmd_word[7:0]))
    else $error("left code write lost");

  // with loading closed the applied codes must not move
  chk_load_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !load_en |=> $stable(state_reg.left_applied) && $stable(state_reg.right_applied))
    else $error("applied code changed while load closed");

  // low codes must show as infinite mute one cycle later
  chk_inf_mute: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg.left_level <= INF_MUTE_MAX |=> left_inf_mute)
    else $error("low code not reported as mute");

  // levels never move without a ramp tick
  chk_ramp_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !ramp_tick |=> $stable(left_level) && $stable(right_level))
    else $error("level moved without a ramp tick");

  // soft mute takes exactly one code per tick toward the floor
  chk_soft_step: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_tick && soft_mute && left_level != ATTEN_FLOOR |=> left_level == $past(left_level) - 8'h01)
    else $error("soft mute step wrong");

  // approach toward a higher applied code is one step per tick
  chk_step_up: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_tick && !soft_mute && left_level < state_reg.left_applied |=> left_level == $past(left_level) + 8'h01)
    else $error("ramp up step wrong");

  // zero-hold mute never acts in stream mode
  chk_zero_stream: assert property (@(posedge clk) disable iff (!rst_n)
    stream_mode |=> !zero_hold_active)
    else $error("zero hold active in stream mode");

  // output disable follows its control bit within one cycle
  chk_out_disable: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg.out_ctrl[OPE_POS] |=> output_disable)
    else $error("output disable not applied");

  // de-emphasis rate and FIR select never both non-zero
  chk_rate_split: assert property (@(posedge clk) disable iff (!rst_n)
    fir_perf_sel != 2'h0 |-> deemph_rate_sel == 2'h0 && $past(stream_mode))
    else $error("rate field used twice");

  // codes reach the applied registers every cycle the gate is open
  chk_load_follow: assert property (@(posedge clk) disable iff (!rst_n)
    load_en |=> state_reg.left_applied == $past(state_reg.left_atten_code))
    else $error("open load gate did not pass the left code");

  // right channel reports low codes as mute too
  chk_right_inf: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg.right_level <= INF_MUTE_MAX |=> right_inf_mute)
    else $error("low right code not reported as mute");

  // codes above the mute range are finite levels
  chk_inf_clear: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg.left_level > INF_MUTE_MAX |=> !left_inf_mute)
    else $error("finite code reported as mute");

  // approach toward a lower target is one step per tick
  chk_step_down: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_tick && left_level > left_target |=> left_level == $past(left_level) - 8'h01)
    else $error("ramp down step wrong");

  // right channel walks down one code per tick as well
  chk_right_step: assert property (@(posedge clk) disable iff (!rst_n)
    ramp_tick && right_level > right_target |=> right_level == $past(right_level) - 8'h01)
    else $error("right ramp step wrong");

  // external filter mode takes the format field away from the audio port
  chk_ext_route: assert property (@(posedge clk) disable iff (!rst_n)
    ext_filter_through |=> ext_format_active && $stable(serial_format_sel))
    else $error("format field not rerouted in external filter mode");

  // normal mode drives the audio format from its field
  chk_fmt_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_filter_through |=> serial_format_sel == $past(state_reg.fmt_ctrl[FMT_LSB +: 3]))
    else $error("audio format does not follow its field");

  // de-emphasis is switched off in stream mode
  chk_deemph_stream: assert property (@(posedge clk) disable iff (!rst_n)
    stream_mode |=> !deemph_enable && deemph_rate_sel == 2'h0)
    else $error("de-emphasis active in stream mode");

  // zero-hold mute needs its enable and both channels zero
  chk_zero_hold: assert property (@(posedge clk) disable iff (!rst_n)
    zero_hold_active |-> $past(zero_left) && $past(zero_right) && $past(state_reg.out_ctrl[ZERO_HOLD_MUTE_ENABLE_POS]))
    else $error("zero hold without both zero flags");

  // polarity follows its control bit one cycle later
  chk_phase_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> phase_invert == $past(state_reg.out_ctrl[REV_POS]))
    else $error("phase invert does not follow its bit");

endmodule : adm_mode_regs
`default_nettype wire

// file: dv/adm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adm_host_model
  import adm_pkg::*;
(
  input  wire logic   clk,
  output logic        cmd_valid,
  output logic [15:0] cmd_word
);
  // bus idles low, no word pending
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = 16'h0000;
  end
  // one word per strobe, launched on the falling edge so the rising edge sees it settled
  task automatic send(input logic rd, input logic [6:0] idx, input logic [7:0] d);
    @(negedge clk);
    cmd_word  = {rd, idx, d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_word  = ~cmd_word; // a released word must not look like the last command
  endtask : send
endmodule : adm_host_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import adm_pkg::*;
;
  typedef struct packed {logic [6:0] idx; logic [7:0] wdat; logic [7:0] rexp;} adm_row_t;
  logic clk = 1'b0, rst_n = 1'b0, word_clock = 1'b0, stream_mode = 1'b0;
  logic ext_filter_through = 1'b0, zero_left = 1'b0, zero_right = 1'b0;
  logic cmd_valid, rd_valid, left_inf_mute, right_inf_mute, ext_format_active;
  logic deemph_enable, phase_invert, output_disable, rolloff_sel, zero_hold_active;
  logic [15:0] cmd_word;
  logic [7:0]  rd_data, left_level, right_level;
  logic [2:0]  serial_format_sel, ext_filter_format;
  logic [1:0]  deemph_rate_sel, fir_perf_sel;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  adm_row_t    rows [7] = '{'{7'h10, 8'h10, 8'h10}, '{7'h11, 8'h80, 8'h80}, '{7'h13, 8'hFF, 8'hF3},
    '{7'h14, 8'h55, 8'h00}, '{7'h12, 8'h3E, 8'h3E}, '{7'h12, 8'h50, 8'h50}, '{7'h13, 8'h00, 8'h00}};

  adm_mode_regs u_adm_mode_regs (.clk, .rst_n, .cmd_valid, .cmd_word, .word_clock, .stream_mode,
    .ext_filter_through, .zero_left, .zero_right, .rd_valid, .rd_data, .left_level, .right_level,
    .left_inf_mute, .right_inf_mute, .serial_format_sel, .ext_filter_format, .ext_format_active,
    .deemph_rate_sel, .fir_perf_sel, .deemph_enable, .phase_invert, .output_disable, .rolloff_sel,
    .zero_hold_active);
  adm_host_model u_adm_host_model (.clk, .cmd_valid, .cmd_word);

  always #20 clk = ~clk;
  // word clock of 16 system clocks, edges on falling clk so the sync chain sees clean levels
  always #320 word_clock = ~word_clock;

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // registered outputs need a cycle past the taking edge
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    u_adm_host_model.send(1'b0, idx, d);
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    u_adm_host_model.send(1'b1, idx, 8'h00);
    check(8'(rd_valid), 8'h01);
    check(rd_data, exp);
    @(negedge clk);
    check(8'(rd_valid), 8'h00);
  endtask : rd

  // cycles until the left level moves; it must fall by exactly one code
  task automatic step(output int k);
    logic [7:0] v;
    v = left_level;
    for (k = 0; k < 300 && left_level === v; k++) @(negedge clk);
    check(left_level, v - 8'h01);
  endtask : step

  task automatic wait_left(input logic [7:0] v);
    for (int k = 0; k < 600 && left_level !== v; k++) @(negedge clk);
  endtask : wait_left

  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(IDX_LEFT_ATTEN, 8'hFF);
    rd(IDX_RIGHT_ATTEN, 8'hFF);
    rd(IDX_FMT_CTRL, 8'h50);
    rd(IDX_OUT_CTRL, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wdat);
      rd(rows[i].idx, rows[i].rexp);
    end
    // codes stored, load gate shut: levels stay put
    repeat (64) @(negedge clk);
    check(left_level, 8'hFF);
    check(right_level, 8'hFF);
    // every audio format and rate code, then the stream and external filter readings
    for (int i = 0; i < 6; i++) begin
      wr(IDX_FMT_CTRL, {1'b0, 3'(i), 2'(i), 2'b10});
      check(8'(serial_format_sel), 8'(i));
      check(8'({deemph_rate_sel, deemph_enable}), 8'({2'(i), 1'b1}));
      stream_mode = 1'b1;
      ext_filter_through = 1'b1;
      repeat (2) @(negedge clk);
      check(8'({fir_perf_sel, deemph_rate_sel, deemph_enable}), 8'({2'(i), 3'b000}));
      check(8'({ext_format_active, ext_filter_format}), 8'({1'b1, 3'(i)}));
      stream_mode = 1'b0;
      ext_filter_through = 1'b0;
    end
    @(negedge clk);
    ext_filter_through = 1'b1;
    wr(IDX_FMT_CTRL, 8'h30);
    check(8'({serial_format_sel, ext_filter_format}), 8'h2B);
    ext_filter_through = 1'b0;
    wr(IDX_OUT_CTRL, 8'h93);
    check(8'({phase_invert, output_disable, rolloff_sel}), 8'h07);
    zero_left = 1'b1;
    repeat (2) @(negedge clk);
    check(8'(zero_hold_active), 8'h00);
    zero_right = 1'b1;
    repeat (2) @(negedge clk);
    check(8'(zero_hold_active), 8'h01);
    stream_mode = 1'b1;
    repeat (2) @(negedge clk);
    check(8'(zero_hold_active), 8'h00);
    stream_mode = 1'b0;
    wr(IDX_OUT_CTRL, 8'h00);
    check(8'({phase_invert, output_disable, rolloff_sel, zero_hold_active}), 8'h00);
    // open the gate; the first interval after a rate change may be short, so time the second
    wr(IDX_FMT_CTRL, 8'hD0);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_OUT_CTRL, 8'(r << ATS_LSB));
      step(n);
      step(n);
      check(8'(n), 8'(16 << r));
    end
    wr(IDX_OUT_CTRL, 8'h00);
    repeat (4200) @(negedge clk);
    check(left_level, 8'h10);
    check(right_level, 8'h80);
    wr(IDX_FMT_CTRL, 8'hD1);
    wait_left(8'h0F);
    repeat (2) @(negedge clk);
    check(8'(left_inf_mute), 8'h00);
    wait_left(8'h0E);
    repeat (2) @(negedge clk);
    check(8'(left_inf_mute), 8'h01);
    repeat (2200) @(negedge clk);
    check(left_level, 8'h00);
    check(right_level, 8'h00);
    check(8'(right_inf_mute), 8'h01);
    // mute off: the left level climbs back to its applied code, one step per tick
    wr(IDX_FMT_CTRL, 8'hD0);
    repeat (320) @(negedge clk);
    check(left_level, 8'h10);
    check(8'(left_inf_mute), 8'h00);
    // reset in mid-run brings the defaults back
    rst_n = 1'b0;
    @(negedge clk);
    check(left_level, 8'hFF);
    check(8'(serial_format_sel), 8'h05);
    rst_n = 1'b1;
    rd(IDX_FMT_CTRL, 8'h50);
    summarize();
  end
endmodule : tb
`default_nettype wire
